// *** design/gpio_pin_group_controller.sv ***
// one pin group: registers, local port, bus slave and pad logic
//
// Design decisions made here: register access over AXI4-Lite and the placing of the registers.
module gpio_pin_group_controller
	import gpio_pkg::*;
#(
	parameter int N = 32,
	parameter int ADDR_W = 12,
	parameter int GROUP_IDX = 0,
	parameter logic [31:0] SPECIAL_MASK = 32'h0000_0000,
	parameter logic [7:0] SPECIAL_CFG = 8'h00
) (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic [ADDR_W-1:0] awaddr_i,
	input wire logic awvalid_i,
	output logic awready_o,
	input wire logic [31:0] wdata_i,
	input wire logic [3:0] wstrb_i,
	input wire logic wvalid_i,
	output logic wready_o,
	output logic [1:0] bresp_o,
	output logic bvalid_o,
	input wire logic bready_i,
	input wire logic [ADDR_W-1:0] araddr_i,
	input wire logic arvalid_i,
	output logic arready_o,
	output logic [31:0] rdata_o,
	output logic [1:0] rresp_o,
	output logic rvalid_o,
	input wire logic rready_i,
	input wire logic debug_access_i,
	input wire logic access_guard_i,
	input wire logic lb_sel_i,
	input wire logic lb_write_i,
	input wire logic [ADDR_W-1:0] lb_addr_i,
	input wire logic [1:0] lb_size_i,
	input wire logic [31:0] lb_wdata_i,
	output logic [31:0] lb_rdata_o,
	input wire logic [N-1:0] pad_in_i,
	output logic [N-1:0] pad_out_o,
	output logic [N-1:0] pad_oe_n_o,
	output logic [N-1:0] pad_ie_o,
	output logic [N-1:0] pad_pull_up_o,
	output logic [N-1:0] pad_pull_down_o,
	input wire logic [N-1:0] periph_out_i,
	input wire logic [N-1:0] periph_oe_i,
	output logic [N-1:0] periph_in_o,
	output logic [4*N-1:0] periph_select_o
);
	localparam int NG = N / 8;

	if (N < 8 || N > 32 || (N % 8) != 0 || ADDR_W < 8) begin : g_chk
		$error("pin count must be 8, 16, 24 or 32");
	end

	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		logic [N-1:0] dir;
		logic [N-1:0] lvl;
		logic [N-1:0] route;
		logic [N-1:0] gate;
		logic [N-1:0] pull;
		logic [4*N-1:0] sel;
		logic [NG-1:0] policy;
		logic [N-1:0] sync1;
		logic [N-1:0] sync2;
		logic aw_rdy;
		logic w_rdy;
		logic ar_rdy;
		logic aw_hold;
		logic [ADDR_W-1:0] aw_addr;
		logic w_hold;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic ar_hold;
		logic [ADDR_W-1:0] ar_addr;
		logic [1:0] rcnt;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [31:0] lb_rdata;
		logic [N-1:0] p_out;
		logic [N-1:0] p_oe_n;
		logic [N-1:0] p_ie;
		logic [N-1:0] p_pu;
		logic [N-1:0] p_pd;
		logic [N-1:0] per_in;
	} state_s;

	state_s q, d;

	// ****************************************
	// decoding helpers
	// ****************************************
	// byte lanes of a local access from its size and low address
	function automatic logic [3:0] lanes(input logic [1:0] sz,
		input logic [1:0] a);
		logic [3:0] r;
		r = 4'hf;
		if (sz == SIZE_BYTE) begin
			r = 4'h1 << a;
		end else if (sz == SIZE_HALF) begin
			r = a[1] ? 4'hc : 4'h3;
		end
		return r;
	endfunction : lanes

	// expand byte lanes to a bit mask
	function automatic logic [31:0] lane_mask(input logic [3:0] be);
		logic [31:0] m;
		m = 32'h0000_0000;
		for (int b = 0; b < 4; b++) begin
			m[8*b +: 8] = {8{be[b]}};
		end
		return m;
	endfunction : lane_mask

	// address falls in this group's window
	function automatic logic in_group(input logic [ADDR_W-1:0] a);
		return (a >> GROUP_SHIFT) == ADDR_W'(GROUP_IDX);
	endfunction : in_group

	// offset names a register that exists
	function automatic logic mapped(input logic [ADDR_W-1:0] a);
		logic [6:0] o;
		o = a[6:0];
		return in_group(a) && ((o <= OFS_SYNC_POLICY)
			|| (o >= OFS_SEL_BASE && o < OFS_SEL_BASE + 7'(N / 2))
			|| (o >= OFS_SETUP_BASE && o < OFS_SETUP_BASE + 7'(N)));
	endfunction : mapped

	// offset is one the local port may reach
	function automatic logic local_ok(input logic [ADDR_W-1:0] a);
		return in_group(a) && a[6:0] <= OFS_IN;
	endfunction : local_ok

	// reset: all pads disabled inputs, special pads take their own setup
	function automatic state_s reset_state();
		state_s s;
		s = '0;
		s.p_oe_n = '1;
		s.route = SPECIAL_MASK[N-1:0] & {N{SPECIAL_CFG[CFG_ROUTE]}};
		s.gate = SPECIAL_MASK[N-1:0] & {N{SPECIAL_CFG[CFG_GATE]}};
		s.pull = SPECIAL_MASK[N-1:0] & {N{SPECIAL_CFG[CFG_PULL]}};
		return s;
	endfunction : reset_state

	// ****************************************
	// next state
	// ****************************************
	logic wr_en;
	logic [6:0] wr_ofs;
	logic [31:0] wr_dat;
	logic [3:0] wr_be;
	logic [6:0] rd_ofs;
	logic [31:0] rd_val;
	logic [31:0] m;
	logic [31:0] dm;
	logic demand;
	logic commit_w;
	logic commit_r;
	logic guarded;
	int pin;
	int wpin;
	logic [N-1:0] analog;

	// read data of the register at rd_ofs
	always_comb begin
		pin = 0;
		rd_val = 32'h0000_0000;
		case (rd_ofs)
			OFS_DIR, OFS_DIR_CLR, OFS_DIR_SET, OFS_DIR_FLIP: begin
				rd_val[N-1:0] = q.dir;
			end
			OFS_LVL, OFS_LVL_CLR, OFS_LVL_SET, OFS_LVL_FLIP: begin
				rd_val[N-1:0] = q.lvl;
			end
			OFS_IN: rd_val[N-1:0] = q.sync2;
			OFS_SYNC_POLICY: rd_val[NG-1:0] = q.policy;
			default: begin
				for (int b = 0; b < 4; b++) begin
					if (rd_ofs >= OFS_SETUP_BASE) begin
						pin = int'(rd_ofs - OFS_SETUP_BASE) + b;
						if (pin < N) begin
							rd_val[8*b + CFG_ROUTE] = q.route[pin];
							rd_val[8*b + CFG_GATE] = q.gate[pin];
							rd_val[8*b + CFG_PULL] = q.pull[pin];
						end
					end else if (rd_ofs >= OFS_SEL_BASE) begin
						pin = 2 * (int'(rd_ofs - OFS_SEL_BASE) + b);
						if (pin < N) begin
							rd_val[8*b +: 8] = q.sel[4*pin +: 8];
						end
					end
				end
			end
		endcase
	end

	always_comb begin
		d = q;
		m = 32'h0000_0000;
		dm = 32'h0000_0000;
		wpin = 0;
		analog = '0;
		guarded = access_guard_i && !debug_access_i;
		// the local port owns the registers in its cycle
		commit_w = q.aw_hold && q.w_hold && !q.bvalid
			&& !lb_sel_i;
		commit_r = q.ar_hold && !q.rvalid && !lb_sel_i;
		demand = q.ar_hold && q.ar_addr[6:0] == OFS_IN;
		// pick the one write of this cycle
		wr_en = 1'b0;
		wr_ofs = lb_addr_i[6:0];
		wr_dat = lb_wdata_i;
		wr_be = lanes(lb_size_i, lb_addr_i[1:0]);
		rd_ofs = q.ar_addr[6:0];
		if (lb_sel_i) begin
			rd_ofs = lb_addr_i[6:0];
			wr_en = lb_write_i && local_ok(lb_addr_i)
				&& !access_guard_i;
			if (!lb_write_i && local_ok(lb_addr_i)) begin
				d.lb_rdata = rd_val & lane_mask(wr_be);
			end
			demand = demand || (!lb_write_i
				&& lb_addr_i[6:0] == OFS_IN);
		end else if (commit_w) begin
			wr_en = mapped(q.aw_addr) && !guarded;
			wr_ofs = q.aw_addr[6:0];
			wr_dat = q.w_data;
			wr_be = q.w_strb;
		end
		// address and data channels are taken in either order
		if (awvalid_i && q.aw_rdy) begin
			d.aw_hold = 1'b1;
			d.aw_addr = awaddr_i;
		end
		if (wvalid_i && q.w_rdy) begin
			d.w_hold = 1'b1;
			d.w_data = wdata_i;
			d.w_strb = wstrb_i;
		end
		if (commit_w) begin
			d.aw_hold = 1'b0;
			d.w_hold = 1'b0;
			d.bvalid = 1'b1;
			d.bresp = (mapped(q.aw_addr) && !guarded)
				? RESP_OKAY : RESP_SLVERR;
		end else if (q.bvalid && bready_i) begin
			d.bvalid = 1'b0;
		end
		// register effect of the chosen write
		m = lane_mask(wr_be);
		dm = wr_dat & m;
		if (wr_en) begin
			case (wr_ofs)
				OFS_DIR: d.dir = (q.dir & ~m[N-1:0]) | dm[N-1:0];
				OFS_DIR_CLR: d.dir = q.dir & ~dm[N-1:0];
				OFS_DIR_SET: d.dir = q.dir | dm[N-1:0];
				OFS_DIR_FLIP: d.dir = q.dir ^ dm[N-1:0];
				OFS_LVL: d.lvl = (q.lvl & ~m[N-1:0]) | dm[N-1:0];
				OFS_LVL_CLR: d.lvl = q.lvl & ~dm[N-1:0];
				OFS_LVL_SET: d.lvl = q.lvl | dm[N-1:0];
				OFS_LVL_FLIP: d.lvl = q.lvl ^ dm[N-1:0];
				OFS_SYNC_POLICY: begin
					if (wr_be[0]) begin
						d.policy = wr_dat[NG-1:0];
					end
				end
				default: begin
					for (int b = 0; b < 4; b++) begin
						if (wr_ofs >= OFS_SETUP_BASE) begin
							wpin = int'(wr_ofs - OFS_SETUP_BASE) + b;
							if (wpin < N && wr_be[b]) begin
								d.route[wpin] = wr_dat[8*b + CFG_ROUTE];
								d.gate[wpin] = wr_dat[8*b + CFG_GATE];
								d.pull[wpin] = wr_dat[8*b + CFG_PULL];
							end
						end else if (wr_ofs >= OFS_SEL_BASE) begin
							wpin = 2 * (int'(wr_ofs - OFS_SEL_BASE) + b);
							if (wpin < N && wr_be[b]) begin
								d.sel[4*wpin +: 8] = wr_dat[8*b +: 8];
							end
						end
					end
				end
			endcase
		end
		// read channel, waiting for on-demand synchronisers
		if (arvalid_i && q.ar_rdy) begin
			d.ar_hold = 1'b1;
			d.ar_addr = araddr_i;
		end
		if (commit_r) begin
			if (demand && !(&q.policy) && q.rcnt != SYNC_WAIT) begin
				d.rcnt = q.rcnt + 2'h1;
			end else begin
				d.rcnt = 2'h0;
				d.ar_hold = 1'b0;
				d.rvalid = 1'b1;
				d.rdata = mapped(q.ar_addr) ? rd_val : 32'h0000_0000;
				d.rresp = mapped(q.ar_addr) ? RESP_OKAY : RESP_SLVERR;
			end
		end else if (q.rvalid && rready_i) begin
			d.rvalid = 1'b0;
		end
		d.aw_rdy = !d.aw_hold;
		d.w_rdy = !d.w_hold;
		d.ar_rdy = !d.ar_hold;
		// per pin: synchronisers and registered pad drive
		d.p_out = '0;
		d.p_oe_n = '1;
		d.p_ie = '0;
		d.p_pu = '0;
		d.p_pd = '0;
		d.per_in = '0;
		for (int p = 0; p < N; p++) begin
			analog[p] = q.route[p] && q.sel[4*p +: 4] == SEL_ANALOG;
			// gated pins are sampled when their group's policy bit is set or on demand; routed ones always are, unless analog
			if ((q.gate[p] && (q.policy[p/8] || demand))
				|| (q.route[p] && !analog[p])) begin
				d.sync1[p] = pad_in_i[p];
				d.sync2[p] = q.sync1[p];
			end
			// an analog pad keeps every digital feature off
			if (analog[p]) begin
				d.p_oe_n[p] = 1'b1;
			end else if (q.route[p]) begin
				d.p_out[p] = periph_out_i[p];
				d.p_oe_n[p] = !periph_oe_i[p];
				d.p_ie[p] = 1'b1;
				d.p_pu[p] = q.pull[p] && !periph_oe_i[p] && q.lvl[p];
				d.p_pd[p] = q.pull[p] && !periph_oe_i[p] && !q.lvl[p];
				d.per_in[p] = q.sync2[p];
			end else begin
				d.p_out[p] = q.lvl[p];
				d.p_oe_n[p] = !q.dir[p];
				d.p_ie[p] = q.gate[p];
				d.p_pu[p] = q.pull[p] && !q.dir[p] && q.lvl[p];
				d.p_pd[p] = q.pull[p] && !q.dir[p] && !q.lvl[p];
			end
		end
	end

	// no sleep or halt input exists, so the group runs whenever clocked
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			q <= reset_state();
		end else begin
			q <= d;
		end
	end

	// outputs come straight from registers; no interrupt line
	assign awready_o = q.aw_rdy;
	assign wready_o = q.w_rdy;
	assign bresp_o = q.bresp;
	assign bvalid_o = q.bvalid;
	assign arready_o = q.ar_rdy;
	assign rdata_o = q.rdata;
	assign rresp_o = q.rresp;
	assign rvalid_o = q.rvalid;
	assign lb_rdata_o = q.lb_rdata;
	assign pad_out_o = q.p_out;
	assign pad_oe_n_o = q.p_oe_n;
	assign pad_ie_o = q.p_ie;
	assign pad_pull_up_o = q.p_pu;
	assign pad_pull_down_o = q.p_pd;
	assign periph_in_o = q.per_in;
	assign periph_select_o = q.sel;

endmodule : gpio_pin_group_controller

// *** design/gpio_pkg.sv ***
// constants shared by the pin group controller
package gpio_pkg;
	// ****************************************
	// register offsets inside one group window
	// ****************************************
	localparam logic [6:0] OFS_DIR = 7'h00;
	localparam logic [6:0] OFS_DIR_CLR = 7'h04;
	localparam logic [6:0] OFS_DIR_SET = 7'h08;
	localparam logic [6:0] OFS_DIR_FLIP = 7'h0c;
	localparam logic [6:0] OFS_LVL = 7'h10;
	localparam logic [6:0] OFS_LVL_CLR = 7'h14;
	localparam logic [6:0] OFS_LVL_SET = 7'h18;
	localparam logic [6:0] OFS_LVL_FLIP = 7'h1c;
	localparam logic [6:0] OFS_IN = 7'h20;
	localparam logic [6:0] OFS_SYNC_POLICY = 7'h24;
	localparam logic [6:0] OFS_SEL_BASE = 7'h30;
	localparam logic [6:0] OFS_SETUP_BASE = 7'h40;
	localparam int GROUP_SHIFT = 7; // groups sit 0x80 bytes apart
	// ****************************************
	// pad setup byte fields and reset values
	// ****************************************
	localparam int CFG_ROUTE = 0;
	localparam int CFG_GATE = 1;
	localparam int CFG_PULL = 2;
	localparam logic [7:0] CFG_RESET = 8'h00;
	localparam logic [3:0] SEL_RESET = 4'h0;
	localparam logic [3:0] SEL_ANALOG = 4'h1;
	// ****************************************
	// local port sizes, timing, bus answers
	// ****************************************
	localparam logic [1:0] SIZE_BYTE = 2'h0;
	localparam logic [1:0] SIZE_HALF = 2'h1;
	localparam logic [1:0] SYNC_WAIT = 2'h2;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : gpio_pkg

// *** tb/gpio_pin_group_controller_assertions.sv ***
// port checker of the pin group controller
module gpio_pin_group_controller_assertions
	import gpio_pkg::*;
#(
	parameter int N = 32
) (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic awvalid_i,
	input wire logic awready_o,
	input wire logic bvalid_o,
	input wire logic bready_i,
	input wire logic [1:0] bresp_o,
	input wire logic arvalid_i,
	input wire logic arready_o,
	input wire logic rvalid_o,
	input wire logic rready_i,
	input wire logic [1:0] rresp_o,
	input wire logic [N-1:0] pad_oe_n_o,
	input wire logic [N-1:0] pad_pull_up_o,
	input wire logic [N-1:0] pad_pull_down_o
);
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (rst_i);
	// ****************************************
	// bus handshakes
	// ****************************************
	sequence s_wr_taken;
		awvalid_i && awready_o;
	endsequence
	sequence s_rd_taken;
		arvalid_i && arready_o;
	endsequence
	a_write_answer: assert property (s_wr_taken |-> ##[1:20] bvalid_o)
		else $error("write not answered");
	a_read_answer: assert property (s_rd_taken |-> ##[1:20] rvalid_o)
		else $error("read not answered");
	a_write_once: assert property (bvalid_o && bready_i |=> !bvalid_o)
		else $error("write answered twice");
	a_read_once: assert property (rvalid_o && rready_i |=> !rvalid_o)
		else $error("read answered twice");
	a_bresp_legal: assert property (bvalid_o |-> !bresp_o[0])
		else $error("bad write response");
	a_rresp_legal: assert property (rvalid_o |-> !rresp_o[0])
		else $error("bad read response");
	// ****************************************
	// pad pulls
	// ****************************************
	a_pull_off_drive: assert property ((~pad_oe_n_o & pad_pull_up_o) == '0
		&& (~pad_oe_n_o & pad_pull_down_o) == '0)
		else $error("pull left on a driven pad");
	a_pull_one_way: assert property ((pad_pull_up_o & pad_pull_down_o) == '0)
		else $error("pull up and down together");
endmodule : gpio_pin_group_controller_assertions

bind gpio_pin_group_controller gpio_pin_group_controller_assertions #(.N(N))
	i_chk (.core_clk_i, .rst_i, .awvalid_i, .awready_o, .bvalid_o, .bready_i,
	.bresp_o, .arvalid_i, .arready_o, .rvalid_o, .rready_i, .rresp_o,
	.pad_oe_n_o, .pad_pull_up_o, .pad_pull_down_o);

// *** tb/pad_board_model.sv ***
// pads and board wiring seen from the controller
module pad_board_model (
	input wire logic [31:0] out_i,
	input wire logic [31:0] oe_n_i,
	input wire logic [31:0] up_i,
	input wire logic [31:0] down_i,
	input wire logic [31:0] ext_i,
	output logic [31:0] pad_o
);
	// a driven pad shows its level, a pulled one its pull, else the board
	assign pad_o = (~oe_n_i & out_i) | (oe_n_i & (up_i | (~down_i & ext_i)));
endmodule : pad_board_model

// *** tb/tb_gpio_pin_group_controller.sv ***
// self-checking bench of the pin group controller
module tb_gpio_pin_group_controller
	import gpio_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk_i = 0, rst_i = 1, debug_access_i = 0, access_guard_i = 0;
	logic awvalid_i = 0, wvalid_i = 0, bready_i = 0, arvalid_i = 0;
	logic rready_i = 0, lb_sel_i = 0, lb_write_i = 0;
	logic awready_o, wready_o, bvalid_o, arready_o, rvalid_o;
	logic [11:0] awaddr_i = '0, araddr_i = '0, lb_addr_i = '0;
	logic [31:0] wdata_i = '0, lb_wdata_i = '0, ext_lvl = 32'h20;
	logic [31:0] periph_out_i = '0, periph_oe_i = '0;
	logic [31:0] rdata_o, lb_rdata_o, pad_in_i, pad_out_o, pad_oe_n_o;
	logic [31:0] pad_ie_o, pad_pull_up_o, pad_pull_down_o, periph_in_o;
	logic [3:0] wstrb_i = '0;
	logic [1:0] bresp_o, rresp_o, lb_size_i = 2'h2;
	logic [127:0] periph_select_o;
	int n_fail = 0, check_count = 0;
	gpio_pin_group_controller i_dut (.core_clk_i(core_clk_i), .rst_i(rst_i),
		.awaddr_i(awaddr_i), .awvalid_i(awvalid_i), .awready_o(awready_o),
		.wdata_i(wdata_i), .wstrb_i(wstrb_i), .wvalid_i(wvalid_i),
		.wready_o(wready_o), .bresp_o(bresp_o), .bvalid_o(bvalid_o),
		.bready_i(bready_i), .araddr_i(araddr_i), .arvalid_i(arvalid_i),
		.arready_o(arready_o), .rdata_o(rdata_o), .rresp_o(rresp_o),
		.rvalid_o(rvalid_o), .rready_i(rready_i),
		.debug_access_i(debug_access_i), .access_guard_i(access_guard_i),
		.lb_sel_i(lb_sel_i), .lb_write_i(lb_write_i), .lb_addr_i(lb_addr_i),
		.lb_size_i(lb_size_i), .lb_wdata_i(lb_wdata_i),
		.lb_rdata_o(lb_rdata_o), .pad_in_i(pad_in_i), .pad_out_o(pad_out_o),
		.pad_oe_n_o(pad_oe_n_o), .pad_ie_o(pad_ie_o),
		.pad_pull_up_o(pad_pull_up_o), .pad_pull_down_o(pad_pull_down_o),
		.periph_out_i(periph_out_i), .periph_oe_i(periph_oe_i),
		.periph_in_o(periph_in_o), .periph_select_o(periph_select_o));
	pad_board_model i_pads (.out_i(pad_out_o), .oe_n_i(pad_oe_n_o),
		.up_i(pad_pull_up_o), .down_i(pad_pull_down_o), .ext_i(ext_lvl),
		.pad_o(pad_in_i));
	always #10 core_clk_i = ~core_clk_i;
	// ****************************************
	// access tasks
	// ****************************************
	task automatic check(string what, logic [31:0] exp, logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			$display("BAD %s exp %h got %h", what, exp, got);
			n_fail++;
		end
	endtask : check
	task automatic wr(logic [11:0] a, logic [31:0] d, logic [3:0] s = 4'hf);
		awaddr_i <= a;
		wdata_i <= d;
		wstrb_i <= s;
		awvalid_i <= 1;
		wvalid_i <= 1;
		bready_i <= 1;
		do begin
			@(posedge core_clk_i);
			if (awready_o) awvalid_i <= 0;
			if (wready_o) wvalid_i <= 0;
		end while (!bvalid_o);
		bready_i <= 0;
		@(posedge core_clk_i);
	endtask : wr
	task automatic rd(logic [11:0] a, output logic [31:0] d);
		araddr_i <= a;
		arvalid_i <= 1;
		rready_i <= 1;
		do begin
			@(posedge core_clk_i);
			if (arready_o) arvalid_i <= 0;
		end while (!rvalid_o);
		d = rdata_o;
		rready_i <= 0;
		@(posedge core_clk_i);
	endtask : rd
	// local port: request taken at one edge, data read one cycle later
	task automatic lb(logic w, logic [11:0] a, logic [31:0] d,
		output logic [31:0] q);
		lb_sel_i <= 1;
		lb_write_i <= w;
		lb_addr_i <= a;
		lb_wdata_i <= d;
		@(posedge core_clk_i);
		lb_sel_i <= 0;
		@(posedge core_clk_i);
		q = lb_rdata_o;
	endtask : lb
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : end_of_test
	// ****************************************
	// tests
	// ****************************************
	initial begin
		logic [31:0] q;
		repeat (6) @(posedge core_clk_i);
		rst_i <= 0;
		check("oe_n", '1, pad_oe_n_o);
		check("ie pull", '0, pad_ie_o | pad_pull_up_o | pad_pull_down_o);
		@(posedge core_clk_i);
		wr(OFS_DIR_SET, 32'hf3);
		wr(OFS_DIR_CLR, 32'h30);
		rd(OFS_DIR, q);
		check("dir", 32'hc3, q);
		check("oe_n", 32'hffffff3c, pad_oe_n_o);
		wr(OFS_LVL_SET, 32'h81);
		wr(OFS_LVL_FLIP, 32'h03);
		wr(OFS_LVL_CLR, 32'h80);
		rd(OFS_LVL, q);
		check("lvl", 32'h02, q);
		check("pad out", 32'h02, pad_out_o & 32'hc3);
		lb(1, OFS_LVL_SET, 32'h40, q);
		lb(1, OFS_DIR_FLIP, 32'h01, q);
		lb_size_i <= SIZE_BYTE;
		lb(1, OFS_LVL_CLR, 32'h02, q);
		lb_size_i <= 2'h2;
		lb(0, OFS_LVL, '0, q);
		check("lb lvl", 32'h40, q);
		lb(0, OFS_DIR, '0, q);
		check("lb dir", 32'hc2, q);
		access_guard_i <= 1;
		wr(OFS_DIR_SET, 32'h100);
		rd(OFS_DIR, q);
		check("guarded", 32'hc2, q);
		debug_access_i <= 1;
		wr(OFS_DIR_SET, 32'h100);
		rd(OFS_DIR, q);
		check("debug", 32'h1c2, q);
		access_guard_i <= 0;
		debug_access_i <= 0;
		wr(OFS_SETUP_BASE + 7'h04, 32'h6, 4'h1);
		check("pull dn", 32'h10, pad_pull_down_o & 32'h10);
		wr(OFS_LVL_SET, 32'h10);
		check("pull up", 32'h10, pad_pull_up_o & 32'h10);
		wr(OFS_DIR_SET, 32'h10);
		check("no pull", '0, (pad_pull_up_o | pad_pull_down_o) & 32'h10);
		rd(OFS_IN, q);
		check("in", 32'h10, q & 32'h30);
		wr(OFS_SYNC_POLICY, 32'hffffffff);
		lb(0, OFS_IN, '0, q);
		check("lb in", 32'h10, q & 32'h30);
		fork
			wr(OFS_LVL_SET, 32'h100);
			begin
				@(posedge core_clk_i);
				lb(1, OFS_LVL_SET, 32'h200, q);
			end
		join
		rd(OFS_LVL, q);
		check("clash", 32'h300, q & 32'h300);
		periph_out_i <= 32'h100;
		periph_oe_i <= 32'h100;
		wr(OFS_SEL_BASE + 7'h04, 32'h23, 4'h1);
		check("select", 32'h23, 32'(periph_select_o[39:32]));
		wr(OFS_SETUP_BASE + 7'h08, 32'h1, 4'h1);
		repeat (3) @(posedge core_clk_i);
		check("routed", 32'h100,
			pad_out_o & ~pad_oe_n_o & periph_in_o & 32'h100);
		wr(OFS_SEL_BASE + 7'h04, 32'h21, 4'h1);
		@(posedge core_clk_i);
		check("analog", 32'h100, pad_oe_n_o & ~pad_ie_o & 32'h100);
		rd(12'h07c, q);
		check("unmapped", 32'h0, q);
		end_of_test();
	end
	// watchdog well beyond the hundred or so cycles the tests need
	initial begin
		#200000;
		n_fail++;
		end_of_test();
	end
endmodule : tb_gpio_pin_group_controller
